//--- core/cps_pkg.sv
// package: register map, field positions, reset values and timing for the pin block
package cps_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_US = 1;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int unsigned TICK_W = 7;
   localparam int unsigned CNT_W = 16;

   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_DELAY = 32'h0000_0004;
   localparam logic [31:0] OFS_DUR = 32'h0000_0008;
   localparam logic [31:0] OFS_STAT = 32'h0000_000c;

   localparam int unsigned CTRL_IN_INV = 0;
   localparam int unsigned CTRL_OUT_INV = 1;
   localparam int unsigned CTRL_SRC_LO = 2;
   localparam int unsigned CTRL_SW_LVL = 4;
   localparam int unsigned CTRL_BOOT_DONE = 5;
   localparam int unsigned STAT_IN_ACT = 0;
   localparam int unsigned STAT_OUT_ACT = 1;

   localparam logic [1:0] SRC_SW = 2'h0;
   localparam logic [1:0] SRC_FILTER = 2'h1;
   localparam logic [1:0] SRC_STROBE = 2'h2;

   localparam logic [15:0] DELAY_RST = 16'h0000;
   localparam logic [15:0] DUR_RST = 16'h03e8;

   typedef struct packed {
      logic in_inv;
      logic out_inv;
      logic [1:0] src;
      logic sw_lvl;
      logic boot_done;
   } cps_ctrl_s;
endpackage

//--- core/cps_pin_strobe.sv
// top: digital in/out pin control with capture strobe, AHB-Lite registers
//
// Overview of operation
// - input polarity normal or inverted
// - software reads input active after polarity
// - output source: software, filter, strobe
// - software source drives written control bit
// - filter source follows cut filter position
// - one strobe pulse per capture start
// - microsecond delay before pulse, default zero
// - microsecond pulse length, default 1000
// - output polarity normal or inverted
// - normal polarity until boot done
// - software reads output active state
// - level write ignored unless software source
module cps_pin_strobe #(
   parameter int unsigned CNT_W = cps_pkg::CNT_W
) (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_in_pin,
   input wire logic i_filter_pos,
   input wire logic i_capture_start,
   output logic o_out_pin
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DELAY = 3'b010,
      ST_PULSE = 3'b100
   } cps_strobe_e;

   cps_pkg::cps_ctrl_s ctrl_q;
   logic [CNT_W-1:0] delay_q;
   logic [CNT_W-1:0] dur_q;
   logic wr_pend_q;
   logic [3:0] wr_sel_q;
   logic [1:0] in_sync_q;
   logic [1:0] flt_sync_q;
   logic [1:0] cap_sync_q;
   logic cap_prev_q;
   logic [cps_pkg::TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   cps_strobe_e st_q;
   cps_strobe_e st_d;
   logic [CNT_W-1:0] us_cnt_q;
   logic [CNT_W-1:0] us_cnt_d;
   logic out_act_q;

   // address phase decode
   wire logic addr_ok = i_hsel & i_hready & i_htrans[1];
   wire logic [3:0] sel_vec = {
      i_haddr[7:0] == cps_pkg::OFS_STAT[7:0],
      i_haddr[7:0] == cps_pkg::OFS_DUR[7:0],
      i_haddr[7:0] == cps_pkg::OFS_DELAY[7:0],
      i_haddr[7:0] == cps_pkg::OFS_CTRL[7:0]};
   wire logic in_act = in_sync_q[1] ^ ctrl_q.in_inv;
   wire logic flt_pos = flt_sync_q[1];
   wire logic cap_edge = cap_sync_q[1] & ~cap_prev_q;
   wire logic strobe_act = (st_q == ST_PULSE);
   wire logic tick_wrap = (tick_cnt_q ==
      cps_pkg::TICK_W'(cps_pkg::TICK_CYC - 1));
   wire logic sw_mode = (ctrl_q.src == cps_pkg::SRC_SW);

   // logical output state by source
   logic out_act_d;
   always_comb begin
      unique case (ctrl_q.src)
         cps_pkg::SRC_SW: out_act_d = ctrl_q.sw_lvl;
         cps_pkg::SRC_FILTER: out_act_d = flt_pos;
         cps_pkg::SRC_STROBE: out_act_d = strobe_act;
         default: out_act_d = 1'b0;
      endcase
   end

   // polarity is held normal until software marks boot complete
   wire logic pin_d = out_act_q ^ (ctrl_q.out_inv & ctrl_q.boot_done);

   wire logic [31:0] rd_mux =
      ({32{sel_vec[0]}} & {26'h0, ctrl_q.boot_done, ctrl_q.sw_lvl,
         ctrl_q.src, ctrl_q.out_inv, ctrl_q.in_inv}) |
      ({32{sel_vec[1]}} & 32'(delay_q)) |
      ({32{sel_vec[2]}} & 32'(dur_q)) |
      ({32{sel_vec[3]}} & {30'h0, out_act_q, in_act});

   // strobe sequencer
   always_comb begin
      st_d = st_q;
      us_cnt_d = us_cnt_q;
      if (cap_edge && ctrl_q.src == cps_pkg::SRC_STROBE) begin
         us_cnt_d = '0;
         if (delay_q == '0) begin
            st_d = (dur_q == '0) ? ST_IDLE : ST_PULSE;
         end else begin
            st_d = ST_DELAY;
         end
      end else if (ctrl_q.src != cps_pkg::SRC_STROBE) begin
         st_d = ST_IDLE;
      end else if (tick_q) begin
         unique case (st_q)
            ST_IDLE: st_d = ST_IDLE;
            ST_DELAY: begin
               us_cnt_d = us_cnt_q + 1'b1;
               if (us_cnt_q + 1'b1 >= delay_q) begin
                  us_cnt_d = '0;
                  st_d = (dur_q == '0) ? ST_IDLE : ST_PULSE;
               end
            end
            ST_PULSE: begin
               us_cnt_d = us_cnt_q + 1'b1;
               if (us_cnt_q + 1'b1 >= dur_q) begin
                  us_cnt_d = '0;
                  st_d = ST_IDLE;
               end
            end
            default: st_d = ST_IDLE;
         endcase
      end
   end

   // microsecond timebase
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
         tick_q <= tick_wrap;
      end
   end

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         in_sync_q <= 2'h0;
         flt_sync_q <= 2'h0;
         cap_sync_q <= 2'h0;
         cap_prev_q <= 1'b0;
      end else begin
         in_sync_q <= {in_sync_q[0], i_in_pin};
         flt_sync_q <= {flt_sync_q[0], i_filter_pos};
         cap_sync_q <= {cap_sync_q[0], i_capture_start};
         cap_prev_q <= cap_sync_q[1];
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_q <= ST_IDLE;
         us_cnt_q <= '0;
         out_act_q <= 1'b0;
         o_out_pin <= 1'b0;
      end else begin
         st_q <= st_d;
         us_cnt_q <= us_cnt_d;
         out_act_q <= out_act_d;
         o_out_pin <= pin_d;
      end
   end

   // bus: address phase latched, write applied in data phase, zero wait
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_pend_q <= 1'b0;
         wr_sel_q <= 4'h0;
      end else begin
         wr_pend_q <= addr_ok & i_hwrite;
         wr_sel_q <= sel_vec;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= '{1'b0, 1'b0, cps_pkg::SRC_SW, 1'b0, 1'b0};
         delay_q <= CNT_W'(cps_pkg::DELAY_RST);
         dur_q <= CNT_W'(cps_pkg::DUR_RST);
      end else if (wr_pend_q) begin
         if (wr_sel_q[0]) begin
            ctrl_q.in_inv <= i_hwdata[cps_pkg::CTRL_IN_INV];
            ctrl_q.out_inv <= i_hwdata[cps_pkg::CTRL_OUT_INV];
            ctrl_q.boot_done <= i_hwdata[cps_pkg::CTRL_BOOT_DONE];
            if (i_hwdata[cps_pkg::CTRL_SRC_LO +: 2] != 2'h3) begin
               ctrl_q.src <= i_hwdata[cps_pkg::CTRL_SRC_LO +: 2];
            end
            // level held unless source already software
            if (sw_mode) begin
               ctrl_q.sw_lvl <= i_hwdata[cps_pkg::CTRL_SW_LVL];
            end
         end
         if (wr_sel_q[1]) begin
            delay_q <= i_hwdata[CNT_W-1:0];
         end
         if (wr_sel_q[2]) begin
            dur_q <= i_hwdata[CNT_W-1:0];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_hrdata <= 32'h0;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         // read data captured at the address edge so it stands in the
         // data phase and is taken at the edge that ends it
         if (addr_ok && !i_hwrite) begin
            o_hrdata <= rd_mux;
         end
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end
endmodule

//--- verif/cps_pin_strobe_checker.sv
// checker: bus and pin relations of the strobe pin block
module cps_pin_strobe_checker (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   input wire logic [31:0] o_hrdata,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   input wire logic i_in_pin,
   input wire logic i_filter_pos,
   input wire logic o_out_pin
);
   wire take = i_hsel & i_hready & i_htrans[1];
   wire ctl_wr = take & i_hwrite & (i_haddr == cps_pkg::OFS_CTRL);
   wire st_rd = take & !i_hwrite & (i_haddr == cps_pkg::OFS_STAT);
   logic wr_q;
   logic [5:0] ctl_q;
   logic [1:0] quiet_q;
   wire [1:0] src = ctl_q[3:2];
   wire flip = ctl_q[1] & ctl_q[5];
   // shadow of the control word, with the same refusals as the block
   wire [5:0] ctl_d = {i_hwdata[5], (src == 2'h0) ? i_hwdata[4] : ctl_q[4],
      (i_hwdata[3:2] == 2'h3) ? src : i_hwdata[3:2], i_hwdata[1:0]};
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_q <= 1'b0;
         ctl_q <= 6'h00;
         quiet_q <= 2'h0;
      end else begin
         wr_q <= ctl_wr;
         if (wr_q)
            ctl_q <= ctl_d;
         if (ctl_wr | wr_q)
            quiet_q <= 2'h0;
         else if (quiet_q != 2'h3)
            quiet_q <= quiet_q + 2'h1;
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   a_ready_high: assert property (o_hreadyout)
      else $error("ready dropped");
   a_resp_okay: assert property (!o_hresp)
      else $error("error response");
   a_boot_normal: assert property ($rose(i_resetn) |-> !o_out_pin)
      else $error("pin active after reset");
   a_sw_drive: assert property (quiet_q == 2'h3 && src == 2'h0
      |-> o_out_pin == (ctl_q[4] ^ flip)) else $error("software level");
   a_filter_follow: assert property ($stable(i_filter_pos)[*5] ##0
      (quiet_q == 2'h3 && src == 2'h1) |-> o_out_pin == (i_filter_pos ^ flip))
      else $error("filter report");
   a_stat_input: assert property ($stable(i_in_pin)[*5] ##0
      (st_rd && quiet_q == 2'h3) |-> ##1 o_hrdata[0] == (i_in_pin ^ ctl_q[0]))
      else $error("input status");
   a_stat_output: assert property (st_rd && quiet_q == 2'h3
      && src == 2'h0 |-> ##1 o_hrdata[1] == ctl_q[4])
      else $error("output status");
   a_unmapped_zero: assert property (take && !i_hwrite
      && i_haddr == 32'h0000_0010 |-> ##1 o_hrdata == 32'h0)
      else $error("unmapped read");
endmodule
bind cps_pin_strobe cps_pin_strobe_checker chk_i (.*);

//--- verif/cps_far_side.sv
// far-side model: capture trigger source and strobe lamp timer
module cps_far_side (
   input wire logic i_ref_clk,
   input wire logic i_lamp,
   input wire logic i_fire,
   output logic o_capture,
   output int o_lit_cyc
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold_q = 0;
   // capture start is a level held for several cycles, as a sensor gives
   always_ff @(posedge i_ref_clk) begin
      if (i_fire) begin
         hold_q <= 8;
         o_lit_cyc <= 0;
      end else begin
         if (hold_q > 0)
            hold_q <= hold_q - 1;
         if (i_lamp)
            o_lit_cyc <= o_lit_cyc + 1;
      end
   end
   assign o_capture = hold_q > 0;
endmodule

//--- verif/cps_pin_strobe_tb.sv
// testbench: registers, pin sources, polarity and strobe timing
module cps_pin_strobe_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, hwrite = 0, in_pin = 0, filt = 0, fire = 0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hrdy, out_pin, cap;
   int lit, failures = 0, checked = 0, cyc = 0;
   cps_pin_strobe dut (.i_ref_clk(clk), .i_resetn(rst_n), .i_hsel(1'b1),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(),
      .i_in_pin(in_pin), .i_filter_pos(filt), .i_capture_start(cap),
      .o_out_pin(out_pin));
   cps_far_side far (.i_ref_clk(clk), .i_lamp(out_pin), .i_fire(fire),
      .o_capture(cap), .o_lit_cyc(lit));
   initial forever #5 clk = ~clk;
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d,
         output logic [31:0] r);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rdc(input logic [31:0] a, m, e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r & m, e);
   endtask
   task automatic pin(input logic e);
      repeat (6) @(posedge clk);
      chk(32'(out_pin), 32'(e));
   endtask
   task automatic t_regs;
      rdc(cps_pkg::OFS_DELAY, 32'hffff, 32'(cps_pkg::DELAY_RST));
      rdc(cps_pkg::OFS_DUR, 32'hffff, 32'(cps_pkg::DUR_RST));
      wr(32'h10, 32'h5);
      rdc(32'h10, 32'hffff_ffff, 32'h0);
   endtask
   task automatic t_sw_and_input;
      wr(cps_pkg::OFS_CTRL, 32'h10);
      pin(1'b1);
      wr(cps_pkg::OFS_CTRL, 32'h12);
      pin(1'b1);
      wr(cps_pkg::OFS_CTRL, 32'h32);
      pin(1'b0);
      rdc(cps_pkg::OFS_STAT, 32'h2, 32'h2);
      in_pin <= 1'b1;
      // the pin passes two synchroniser stages before status sees it
      repeat (4) @(posedge clk);
      rdc(cps_pkg::OFS_STAT, 32'h1, 32'h1);
      wr(cps_pkg::OFS_CTRL, 32'h1);
      repeat (2) @(posedge clk);
      rdc(cps_pkg::OFS_STAT, 32'h3, 32'h0);
   endtask
   task automatic t_filter;
      wr(cps_pkg::OFS_CTRL, 32'h04);
      filt <= 1'b1;
      pin(1'b1);
      filt <= 1'b0;
      pin(1'b0);
   endtask
   task automatic t_strobe;
      wr(cps_pkg::OFS_DELAY, 32'h2);
      wr(cps_pkg::OFS_DUR, 32'h3);
      wr(cps_pkg::OFS_CTRL, 32'h08);
      repeat (2) begin
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
         repeat (50) @(posedge clk);
         chk(32'(out_pin), 32'h0);
         repeat (800) @(posedge clk);
         chk(32'(lit inside {[200:400]}), 32'h1);
      end
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (250) @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (900) @(posedge clk);
      chk(32'(lit inside {[200:400]}), 32'h1);
      wr(cps_pkg::OFS_CTRL, 32'h18);
      wr(cps_pkg::OFS_CTRL, 32'h10);
      pin(1'b0);
      wr(cps_pkg::OFS_CTRL, 32'h10);
      pin(1'b1);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_sw_and_input();
      t_filter();
      t_strobe();
      report_and_stop();
   end
endmodule
